// ### core/sgc_params.svh
// offsets, field positions, reset values for sleep clock gating control
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

`define SGC_BASE_ADDR      32'h400fe000
`define SGC_OFF_RUN_CFG    12'h000
`define SGC_OFF_IRQ_STAT   12'h008
`define SGC_OFF_IRQ_MASK   12'h00c
`define SGC_OFF_RUN_GATE   12'h104
`define SGC_OFF_SLEEP_GATE 12'h114
`define SGC_OFF_DEEP_GATE  12'h124

`define SGC_GATE_RESET     32'h00000000
`define SGC_GATE_WR_MASK   32'h070f1111
`define SGC_CFG_RESET      32'h00000000
`define SGC_AUTO_GATE_BIT  0

`define SGC_IRQ_W          3
`define SGC_IRQ_FAULT      0
`define SGC_IRQ_SLEEP      1
`define SGC_IRQ_WAKE       2

`define SGC_RESP_OKAY      2'b00
`define SGC_RESP_SLVERR    2'b10

`endif

// ### core/sgc_pkg.sv
// types shared by the sleep clock gating control block
package sgc_pkg;
    typedef enum logic [1:0] {
        sgc_mode_run   = 2'b00,
        sgc_mode_sleep = 2'b01,
        sgc_mode_deep  = 2'b11
    } sgc_mode_e;

    typedef enum logic [2:0] {
        sgc_reg_none,
        sgc_reg_cfg,
        sgc_reg_stat,
        sgc_reg_mask,
        sgc_reg_run,
        sgc_reg_sleep,
        sgc_reg_deep
    } sgc_reg_e;

    typedef logic [31:0] sgc_word_t;
endpackage

// ### core/sgc_clk_gate.sv
// glitch-free clock gate for one peripheral
`timescale 1ns/100ps
module sgc_clk_gate (
    input  wire logic clk,
    input  wire logic en,
    output logic      gclk
);
    logic en_l;

    // enable only changes while clk is low
    always_latch begin
        if (!clk) begin
            en_l <= en;
        end
    end

    assign gclk = clk & en_l;
endmodule

// ### core/sgc_irq.sv
// sticky event status with write-one-to-clear and masked interrupt
`timescale 1ns/100ps
`include "sgc_params.svh"
module sgc_irq (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic [`SGC_IRQ_W-1:0]  evt,
    input  wire logic                   clr_we,
    input  wire logic [`SGC_IRQ_W-1:0]  clr_bits,
    input  wire logic [`SGC_IRQ_W-1:0]  mask,
    output logic      [`SGC_IRQ_W-1:0]  stat_q,
    output logic                        irq
);
    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~(clr_we ? clr_bits : '0)) | evt;
        end
    end

    assign irq = |(stat_q & mask);

    set_wins_a: assert property (@(posedge clk) disable iff (!resetn)
        evt != '0 |=> (stat_q & $past(evt)) == $past(evt))
        else $error("event lost in status");
endmodule

// ### core/sgc_top.sv
// sleep clock gating control: gating registers, mode select, fault check, axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "sgc_params.svh"

// Functional notes
// - set gating bit clocks its peripheral in sleep; clear bit leaves it unclocked, disabled.
// - access to a peripheral whose clock is gated off raises a bus fault.
// - all sleep gating bits are zero after reset.
// - run register applies when running, sleep register in sleep, deep register in deep sleep.
// - sleep-mode registers apply only when the automatic gating select bit is set.
// - bits 26, 25, 24 gate comparators 2, 1, 0; read and write.
// - bits 19 to 16 gate timers 3 to 0; read and write.
// - bit 12 gates the two-wire port; read and write.
// - bit 8 gates the quadrature decoder; read and write.
// - bit 4 gates the synchronous serial port; read and write.
// - bit 0 gates the asynchronous serial port; read and write.
// - reserved bits read zero and ignore writes.
// - sleep gating register decodes at base 0x400fe000 plus 0x114.
// - run gating register, same layout, decodes at offset 0x104.
module sgc_top (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [31:0]       s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire sgc_pkg::sgc_word_t s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [31:0]       s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output sgc_pkg::sgc_word_t     s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              sleep_req,
    input  wire logic              deep_sleep_req,
    input  wire logic              periph_acc_valid,
    input  wire logic [31:0]       periph_acc_sel,
    output logic                   periph_fault,
    output logic [31:0]            periph_en,
    output logic [31:0]            periph_gclk,
    output logic                   irq
);
    import sgc_pkg::*;

    localparam sgc_word_t WR_MASK = `SGC_GATE_WR_MASK;
    localparam sgc_word_t BASE    = `SGC_BASE_ADDR;
    localparam sgc_word_t CFG_RESET = `SGC_CFG_RESET;

    sgc_word_t               run_gating_reg_q;
    sgc_word_t               sleep_gating_reg_q;
    sgc_word_t               deep_sleep_gating_reg_q;
    logic                    auto_gating_select_q;
    logic [`SGC_IRQ_W-1:0]   irq_mask_q;
    logic [`SGC_IRQ_W-1:0]   irq_stat;
    sgc_mode_e               mode_q;
    sgc_mode_e               mode_d;
    sgc_word_t               sel_gates;
    sgc_word_t               en_q;
    logic                    fault_q;
    logic                    fault_d;
    logic                    aw_hold_q;
    logic                    w_hold_q;
    logic [31:0]             awaddr_q;
    sgc_word_t               wdata_q;
    logic [3:0]              wstrb_q;
    logic                    bvalid_q;
    logic [1:0]              bresp_q;
    logic                    rvalid_q;
    logic [1:0]              rresp_q;
    sgc_word_t               rdata_q;
    sgc_word_t               rdata_d;
    sgc_reg_e                wsel;
    sgc_reg_e                rsel;
    logic                    wr_go;
    logic                    ar_go;
    logic [`SGC_IRQ_W-1:0]   events;

    // address decode, used for both read and write channels
    function automatic sgc_reg_e decode(input logic [31:0] a);
        sgc_reg_e r;
        r = sgc_reg_none;
        if (a[31:12] == BASE[31:12] && a[1:0] == 2'b00) begin
            unique case (a[11:0])
                `SGC_OFF_RUN_CFG:    r = sgc_reg_cfg;
                `SGC_OFF_IRQ_STAT:   r = sgc_reg_stat;
                `SGC_OFF_IRQ_MASK:   r = sgc_reg_mask;
                `SGC_OFF_RUN_GATE:   r = sgc_reg_run;
                `SGC_OFF_SLEEP_GATE: r = sgc_reg_sleep;
                `SGC_OFF_DEEP_GATE:  r = sgc_reg_deep;
                default:             r = sgc_reg_none;
            endcase
        end
        return r;
    endfunction

    // byte-lane merge honouring write strobes
    function automatic sgc_word_t merge(input sgc_word_t old_v, input sgc_word_t new_v,
                                        input logic [3:0] strb);
        sgc_word_t r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign wr_go         = aw_hold_q && w_hold_q && !bvalid_q;
    assign wsel          = decode(awaddr_q);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            w_hold_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_go) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `SGC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == sgc_reg_none) ? `SGC_RESP_SLVERR : `SGC_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // gating registers: only documented gate bits are writable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            run_gating_reg_q <= `SGC_GATE_RESET;
        end else if (wr_go && wsel == sgc_reg_run) begin
            run_gating_reg_q <= merge(run_gating_reg_q, wdata_q, wstrb_q) & WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sleep_gating_reg_q <= `SGC_GATE_RESET;
        end else if (wr_go && wsel == sgc_reg_sleep) begin
            sleep_gating_reg_q <= merge(sleep_gating_reg_q, wdata_q, wstrb_q) & WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            deep_sleep_gating_reg_q <= `SGC_GATE_RESET;
        end else if (wr_go && wsel == sgc_reg_deep) begin
            deep_sleep_gating_reg_q <= merge(deep_sleep_gating_reg_q, wdata_q, wstrb_q) & WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            auto_gating_select_q <= CFG_RESET[`SGC_AUTO_GATE_BIT];
        end else if (wr_go && wsel == sgc_reg_cfg && wstrb_q[0]) begin
            auto_gating_select_q <= wdata_q[`SGC_AUTO_GATE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_mask_q <= '0;
        end else if (wr_go && wsel == sgc_reg_mask && wstrb_q[0]) begin
            irq_mask_q <= wdata_q[`SGC_IRQ_W-1:0];
        end
    end

    // read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_q;
    assign ar_go         = s_axi_arvalid && s_axi_arready;
    assign rsel          = decode(s_axi_araddr);

    always_comb begin
        rdata_d = '0;
        unique case (rsel)
            sgc_reg_cfg:   rdata_d[`SGC_AUTO_GATE_BIT] = auto_gating_select_q;
            sgc_reg_stat:  rdata_d[`SGC_IRQ_W-1:0] = irq_stat;
            sgc_reg_mask:  rdata_d[`SGC_IRQ_W-1:0] = irq_mask_q;
            sgc_reg_run:   rdata_d = run_gating_reg_q;
            sgc_reg_sleep: rdata_d = sleep_gating_reg_q;
            sgc_reg_deep:  rdata_d = deep_sleep_gating_reg_q;
            sgc_reg_none:  rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `SGC_RESP_OKAY;
            rdata_q  <= '0;
        end else if (ar_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= (rsel == sgc_reg_none) ? `SGC_RESP_SLVERR : `SGC_RESP_OKAY;
            rdata_q  <= rdata_d;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

    // system mode tracking, deep sleep has priority
    always_comb begin
        if (deep_sleep_req) begin
            mode_d = sgc_mode_deep;
        end else if (sleep_req) begin
            mode_d = sgc_mode_sleep;
        end else begin
            mode_d = sgc_mode_run;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_q <= sgc_mode_run;
        end else begin
            mode_q <= mode_d;
        end
    end

    // gating register selection per mode
    always_comb begin
        sel_gates = run_gating_reg_q;
        if (auto_gating_select_q) begin
            unique case (mode_q)
                sgc_mode_run:   sel_gates = run_gating_reg_q;
                sgc_mode_sleep: sel_gates = sleep_gating_reg_q;
                sgc_mode_deep:  sel_gates = deep_sleep_gating_reg_q;
                default:        sel_gates = run_gating_reg_q;
            endcase
        end
    end

    // registered enables feed latch gates, so switching is glitch free
    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_q <= `SGC_GATE_RESET;
        end else begin
            en_q <= sel_gates & WR_MASK;
        end
    end

    assign periph_en = en_q;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_gate
            if (WR_MASK[gi]) begin : g_on
                sgc_clk_gate u_gate (
                    .clk  (clk),
                    .en   (en_q[gi]),
                    .gclk (periph_gclk[gi])
                );
            end else begin : g_off
                assign periph_gclk[gi] = 1'b0;
            end
        end
    endgenerate

    // access to an unclocked peripheral faults
    assign fault_d = periph_acc_valid && |(periph_acc_sel & ~en_q);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

    assign periph_fault = fault_q;

    // events: fault, entry into a low-power mode, return to run
    always_comb begin
        events                   = '0;
        events[`SGC_IRQ_FAULT]   = fault_q;
        events[`SGC_IRQ_SLEEP]   = (mode_q == sgc_mode_run) && (mode_d != sgc_mode_run);
        events[`SGC_IRQ_WAKE]    = (mode_q != sgc_mode_run) && (mode_d == sgc_mode_run);
    end

    sgc_irq u_irq (
        .clk      (clk),
        .resetn   (resetn),
        .evt      (events),
        .clr_we   (wr_go && wsel == sgc_reg_stat && wstrb_q[0]),
        .clr_bits (wdata_q[`SGC_IRQ_W-1:0]),
        .mask     (irq_mask_q),
        .stat_q   (irq_stat),
        .irq      (irq)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    reset_gates_a: assert property (
        $past(!resetn) |-> sleep_gating_reg_q == '0 && en_q == '0)
        else $error("gates not zero after reset");

    sleep_apply_a: assert property (
        auto_gating_select_q && mode_q == sgc_mode_sleep |=> en_q == $past(sleep_gating_reg_q))
        else $error("sleep register not applied");

    run_only_a: assert property (
        !auto_gating_select_q |=> en_q == $past(run_gating_reg_q))
        else $error("run register not applied without auto gating");

    reserved_zero_a: assert property (
        ((sleep_gating_reg_q | run_gating_reg_q | deep_sleep_gating_reg_q) & ~WR_MASK) == '0)
        else $error("reserved gate bit set");

    fault_raise_a: assert property (
        periph_acc_valid && (periph_acc_sel & ~en_q) != '0 |=> periph_fault)
        else $error("gated access did not fault");

    fault_quiet_a: assert property (
        !(periph_acc_valid && (periph_acc_sel & ~en_q) != '0) |=> !periph_fault)
        else $error("fault without gated access");

    sleep_write_a: assert property (
        wr_go && awaddr_q == (BASE | 32'h00000114) && wstrb_q == 4'hf
        |=> sleep_gating_reg_q == ($past(wdata_q) & WR_MASK) && s_axi_bresp == 2'b00)
        else $error("sleep gating write at 0x114 failed");

    run_write_a: assert property (
        wr_go && awaddr_q == (BASE | 32'h00000104) && wstrb_q == 4'hf
        |=> run_gating_reg_q == ($past(wdata_q) & WR_MASK) ##1 en_q[0] == $past(run_gating_reg_q[0], 1)
        || auto_gating_select_q)
        else $error("run gating write at 0x104 failed");

    gate_track_a: assert property (
        $stable(sel_gates) [*2] |-> periph_en == (sel_gates & WR_MASK))
        else $error("peripheral enable does not follow selected gates");
endmodule

// ### tb/tb_sleep_clock_gating_control.sv
// self-checking bench for the sleep clock gating control block
`timescale 1ns/100ps
`include "sgc_params.svh"
module tb_sleep_clock_gating_control;
    import sgc_pkg::*;
    logic        clk, resetn;
    logic [31:0] s_axi_awaddr, s_axi_araddr, periph_acc_sel;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    sgc_word_t   s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, sleep_req, deep_sleep_req;
    logic        periph_acc_valid, periph_fault, irq;
    logic [31:0] periph_en, periph_gclk, d;
    logic [1:0]  r;
    int          err_count, compares;

    sgc_top DUT (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .periph_acc_valid(periph_acc_valid), .periph_acc_sel(periph_acc_sel),
        .periph_fault(periph_fault), .periph_en(periph_en), .periph_gclk(periph_gclk),
        .irq(irq));

    always #10 clk = ~clk;

    function automatic logic [31:0] ad(input logic [11:0] off);
        return `SGC_BASE_ADDR + {20'h00000, off};
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %b exp %b", $time, m, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s resp %b exp %b", $time, m, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s,
                          output logic [1:0] resp);
        logic ad_ok, wd_ok, ta, tw, b;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        ad_ok = 1'b0;
        wd_ok = 1'b0;
        while (!(ad_ok && wd_ok)) begin
            @(negedge clk);
            ta = s_axi_awready && !ad_ok;
            tw = s_axi_wready && !wd_ok;
            @(posedge clk);
            if (ta) begin
                ad_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (tw) begin
                wd_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        b = 1'b0;
        while (!b) begin
            @(negedge clk);
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk);
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic t;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = s_axi_arready;
            @(posedge clk);
        end
        s_axi_arvalid <= 1'b0;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = s_axi_rvalid;
            v = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk);
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] off, input logic [31:0] v);
        logic [1:0] rs;
        axi_wr(ad(off), v, 4'hf, rs);
        chk_resp(rs, 2'b00, "write");
    endtask

    task automatic rdchk(input logic [11:0] off, input logic [31:0] exp, input string m);
        logic [31:0] v;
        logic [1:0]  rs;
        axi_rd(ad(off), v, rs);
        chk_resp(rs, 2'b00, m);
        chk_word(v, exp, m);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        rdchk(`SGC_OFF_SLEEP_GATE, 32'h00000000, "sleep reset");
        rdchk(`SGC_OFF_RUN_GATE, 32'h00000000, "run reset");
        rdchk(`SGC_OFF_DEEP_GATE, 32'h00000000, "deep reset");
        rdchk(`SGC_OFF_RUN_CFG, 32'h00000000, "cfg reset");
        chk_word(periph_en, 32'h00000000, "enables after reset");
        chk_bit(irq, 1'b0, "irq after reset");
        $display("test reset done");
    endtask

    task automatic t_regs();
        for (int i = 0; i < 32; i++) begin
            wr(`SGC_OFF_SLEEP_GATE, 32'h1 << i);
            rdchk(`SGC_OFF_SLEEP_GATE, (32'h1 << i) & 32'h070f1111, "sleep bit");
        end
        wr(`SGC_OFF_SLEEP_GATE, 32'hffffffff);
        axi_wr(ad(`SGC_OFF_SLEEP_GATE), 32'h00000000, 4'b1000, r);
        rdchk(`SGC_OFF_SLEEP_GATE, 32'h000f1111, "byte strobe");
        wr(`SGC_OFF_RUN_GATE, 32'hffffffff);
        rdchk(`SGC_OFF_RUN_GATE, 32'h070f1111, "run layout");
        axi_rd(ad(12'h200), d, r);
        chk_resp(r, 2'b10, "unmapped read");
        chk_word(d, 32'h00000000, "unmapped data");
        axi_wr(ad(12'h116), 32'h0, 4'hf, r);
        chk_resp(r, 2'b10, "misaligned write");
        axi_wr(32'h500fe114, 32'h0, 4'hf, r);
        chk_resp(r, 2'b10, "wrong base write");
        rdchk(`SGC_OFF_SLEEP_GATE, 32'h000f1111, "no effect");
        axi_rd(ad(`SGC_OFF_SLEEP_GATE), d, r);
        wr(`SGC_OFF_SLEEP_GATE, d | 32'h04000000);
        rdchk(`SGC_OFF_SLEEP_GATE, 32'h040f1111, "read-modify-write");
        $display("test registers done");
    endtask

    task automatic t_gating();
        wr(`SGC_OFF_RUN_GATE, 32'h00000011);
        wr(`SGC_OFF_SLEEP_GATE, 32'h07000100);
        wr(`SGC_OFF_DEEP_GATE, 32'h00001000);
        @(posedge clk);
        sleep_req <= 1'b1;
        settle();
        chk_word(periph_en, 32'h00000011, "auto off keeps run");
        wr(`SGC_OFF_RUN_CFG, 32'h00000001);
        settle();
        chk_word(periph_en, 32'h07000100, "sleep enables");
        @(posedge clk);
        #1;
        chk_word(periph_gclk, 32'h07000100, "clock high phase");
        @(negedge clk);
        #1;
        chk_word(periph_gclk, 32'h00000000, "clock low phase");
        @(posedge clk);
        deep_sleep_req <= 1'b1;
        settle();
        chk_word(periph_en, 32'h00001000, "deep enables");
        @(posedge clk);
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        settle();
        chk_word(periph_en, 32'h00000011, "run enables");
        $display("test gating done");
    endtask

    task automatic t_fault();
        rdchk(`SGC_OFF_IRQ_STAT, 32'h00000006, "mode entry and wake events");
        wr(`SGC_OFF_IRQ_STAT, 32'h00000007);
        wr(`SGC_OFF_IRQ_MASK, 32'h00000001);
        rdchk(`SGC_OFF_IRQ_MASK, 32'h00000001, "mask readback");
        @(posedge clk);
        periph_acc_valid <= 1'b1;
        periph_acc_sel <= 32'h00000001;
        @(posedge clk);
        periph_acc_sel <= 32'h00000100;
        #1;
        chk_bit(periph_fault, 1'b0, "enabled access");
        @(posedge clk);
        periph_acc_valid <= 1'b0;
        #1;
        chk_bit(periph_fault, 1'b1, "gated access faults");
        @(posedge clk);
        #1;
        chk_bit(periph_fault, 1'b0, "fault one cycle");
        chk_bit(irq, 1'b1, "irq on fault");
        rdchk(`SGC_OFF_IRQ_STAT, 32'h00000001, "fault status");
        wr(`SGC_OFF_IRQ_STAT, 32'h00000001);
        @(negedge clk);
        chk_bit(irq, 1'b0, "irq cleared");
        $display("test fault done");
    endtask

    task automatic end_of_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #400us;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, periph_acc_sel} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {sleep_req, deep_sleep_req, periph_acc_valid} = '0;
        err_count = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_gating();
        t_fault();
        end_of_test();
    end
endmodule
